// ---- fwc_assertions.sv ----
// port checker for the flash command controller
// assumes it is bound onto fwc_controller
`timescale 1ns/1ps
`include "fwc_cfg.svh"
module fwc_assertions
    import fwc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input fwc_pkg::fwc_req_s req_in,
    input wire logic [`FWC_DATA_W-1:0] dq_in,
    input wire logic req_ready_out,
    input wire logic done_out,
    input fwc_pkg::fwc_err_s err_out,
    input wire logic err_any_out,
    input wire logic [`FWC_ADDR_W-1:0] addr_out,
    input wire logic [`FWC_DATA_W-1:0] dq_out,
    input wire logic dq_oe_out,
    input wire logic ce_n_out,
    input wire logic we_n_out,
    input wire logic oe_n_out,
    input wire logic reset_powerdown_pin_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    done_pulse_a: assert property (done_out |=> !done_out && req_ready_out)
        else $error("done not a single pulse followed by ready");
    accept_busy_a: assert property (req_valid_in && req_ready_out |=> !req_ready_out && err_out == '0)
        else $error("accept did not leave idle or clear errors");
    strobe_excl_a: assert property (!(!we_n_out && !oe_n_out))
        else $error("write and read strobes low together");
    write_drive_a: assert property (!we_n_out |-> !ce_n_out && dq_oe_out)
        else $error("write strobe without select or data drive");
    write_len_a: assert property ($fell(we_n_out) |-> !we_n_out[*3] ##1 we_n_out)
        else $error("write strobe width wrong");
    read_float_a: assert property (!oe_n_out |-> !dq_oe_out && !ce_n_out)
        else $error("data driven during a read");
    pin_high_a: assert property ($past(rst_n_in) |-> reset_powerdown_pin_out)
        else $error("reset pin low in operation");
    setup_code_a: assert property (req_valid_in && req_ready_out && req_in.op == FWC_OP_PROGRAM
        |-> ##[1:6] (!we_n_out && dq_out == `FWC_CMD_PROGRAM))
        else $error("program setup code missing");
    lock_code_a: assert property (req_valid_in && req_ready_out && req_in.op == FWC_OP_CLEAR_LOCKS
        |-> ##[1:6] (!we_n_out && dq_out == `FWC_CMD_LOCK_SETUP))
        else $error("lock setup code missing");
endmodule
bind fwc_controller fwc_assertions chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .dq_in(dq_in), .req_ready_out(req_ready_out),
    .done_out(done_out), .err_out(err_out), .err_any_out(err_any_out), .addr_out(addr_out),
    .dq_out(dq_out), .dq_oe_out(dq_oe_out), .ce_n_out(ce_n_out), .we_n_out(we_n_out),
    .oe_n_out(oe_n_out), .reset_powerdown_pin_out(reset_powerdown_pin_out));

// ---- fwc_bus_cycle.sv ----
// one asynchronous flash bus cycle, write or read, with fixed strobe timing
// assumes the flash data pins are sampled synchronously to the clock
`timescale 1ns/1ps
`include "fwc_cfg.svh"
module fwc_bus_cycle (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic write_in,
    input wire logic [`FWC_ADDR_W-1:0] addr_in,
    input wire logic [`FWC_DATA_W-1:0] wdata_in,
    input wire logic [`FWC_DATA_W-1:0] dq_in,
    output fwc_pkg::fwc_bus_s bus_out,
    output logic [`FWC_DATA_W-1:0] rdata_out,
    output logic done_out
);
    import fwc_pkg::*;
    typedef enum logic [1:0] {CYC_IDLE, CYC_STROBE, CYC_HOLD} fwc_cyc_e;
    typedef struct packed {
        fwc_cyc_e st;
        logic [`FWC_CNT_W-1:0] cnt;
        logic wr;
        fwc_bus_s bus;
        logic [`FWC_DATA_W-1:0] rdata;
        logic done;
    } fwc_cyc_state_s;
    fwc_cyc_state_s s;
    fwc_cyc_state_s next_s;
    localparam fwc_bus_s BUS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
    localparam logic [`FWC_CNT_W-1:0] PHASE = `FWC_CNT_W'(`FWC_PHASE_CYC);

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        unique case (s.st)
            CYC_IDLE: begin
                if (start_in) begin
                    next_s.st = CYC_STROBE;
                    next_s.cnt = PHASE;
                    next_s.wr = write_in;
                    next_s.bus.ce_n = 1'b0;
                    next_s.bus.we_n = ~write_in;
                    next_s.bus.oe_n = write_in;
                    next_s.bus.addr = addr_in;
                    next_s.bus.dq_out = wdata_in;
                    next_s.bus.dq_oe = write_in;
                end
            end
            CYC_STROBE: begin
                if (s.cnt == `FWC_CNT_W'(1)) begin
                    // data is latched by the flash on the rising write strobe; keep dq driven one more phase
                    next_s.st = CYC_HOLD;
                    next_s.cnt = PHASE;
                    next_s.bus.we_n = 1'b1;
                    next_s.bus.oe_n = 1'b1;
                    next_s.bus.ce_n = 1'b1;
                    if (!s.wr) begin
                        next_s.rdata = dq_in;
                    end
                end else begin
                    next_s.cnt = s.cnt - `FWC_CNT_W'(1);
                end
            end
            CYC_HOLD: begin
                if (s.cnt == `FWC_CNT_W'(1)) begin
                    next_s.st = CYC_IDLE;
                    next_s.bus.dq_oe = 1'b0;
                    next_s.done = 1'b1;
                end else begin
                    next_s.cnt = s.cnt - `FWC_CNT_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '{st: CYC_IDLE, cnt: '0, wr: 1'b0, bus: BUS_IDLE, rdata: '0, done: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign bus_out = s.bus;
    assign rdata_out = s.rdata;
    assign done_out = s.done;
endmodule

// ---- fwc_cfg.svh ----
// constants for the flash write/lock command controller
// assumes a 25 MHz system clock and an x16 asynchronous flash bus
`ifndef FWC_CFG_SVH
`define FWC_CFG_SVH
`define FWC_CMD_PROGRAM 16'h0040
`define FWC_CMD_LOCK_SETUP 16'h0060
`define FWC_CMD_BLOCK_LOCK 16'h0001
`define FWC_CMD_PERM_LOCK 16'h00f1
`define FWC_CMD_CLEAR_LOCKS 16'h00d0
`define FWC_CMD_READ_ARRAY 16'h00ff
`define FWC_CMD_CLEAR_STATUS 16'h0050
`define FWC_BIT_READY 7
`define FWC_BIT_WRITE_ERR 4
`define FWC_BIT_SUPPLY_ERR 3
`define FWC_BIT_PROTECT 1
// each bus strobe phase lasts this many ns
`define FWC_PHASE_NS 120
`define FWC_CLK_NS 40
`define FWC_PHASE_CYC (((`FWC_PHASE_NS) + (`FWC_CLK_NS) - 1) / (`FWC_CLK_NS))
`define FWC_CNT_W 4
`define FWC_ADDR_W 19
`define FWC_DATA_W 16
`endif

// ---- fwc_controller.sv ----
// host-side controller that sequences program and lock-bit commands into a parallel flash
// assumes the flash pins are synchronous to ref_clk_in; user requests are held until accepted
`timescale 1ns/1ps
`include "fwc_cfg.svh"
module fwc_controller (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input fwc_pkg::fwc_req_s req_in,
    input wire logic [`FWC_DATA_W-1:0] dq_in,
    output logic req_ready_out,
    output logic done_out,
    output fwc_pkg::fwc_err_s err_out,
    output logic err_any_out,
    output logic [`FWC_ADDR_W-1:0] addr_out,
    output logic [`FWC_DATA_W-1:0] dq_out,
    output logic dq_oe_out,
    output logic ce_n_out,
    output logic we_n_out,
    output logic oe_n_out,
    output logic reset_powerdown_pin_out
);
    import fwc_pkg::*;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FIRST, ST_SECOND, ST_POLL, ST_CLEAR, ST_FINISH
    } fwc_state_e;
    typedef struct packed {
        fwc_state_e st;
        fwc_req_s req;
        logic busy;
        logic done;
        fwc_err_s err;
        logic err_any;
        logic rp_n;
        logic ready;
    } fwc_ctl_state_s;
    fwc_ctl_state_s s;
    fwc_ctl_state_s next_s;
    logic cyc_start;
    logic cyc_write;
    logic [`FWC_ADDR_W-1:0] cyc_addr;
    logic [`FWC_DATA_W-1:0] cyc_data;
    fwc_bus_s cyc_bus;
    logic [`FWC_DATA_W-1:0] cyc_rdata;
    logic cyc_done;
    logic [`FWC_DATA_W-1:0] first_code;
    logic [`FWC_DATA_W-1:0] second_code;
    logic two_cycle;
    logic cyc_pending;
    logic cyc_issued;

    fwc_bus_cycle u_cycle (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(cyc_start),
        .write_in(cyc_write),
        .addr_in(cyc_addr),
        .wdata_in(cyc_data),
        .dq_in(dq_in),
        .bus_out(cyc_bus),
        .rdata_out(cyc_rdata),
        .done_out(cyc_done)
    );

    // codes of each command sequence
    always_comb begin
        first_code = `FWC_CMD_READ_ARRAY;
        second_code = `FWC_CMD_READ_ARRAY;
        two_cycle = 1'b0;
        unique case (s.req.op)
            FWC_OP_PROGRAM: begin
                first_code = `FWC_CMD_PROGRAM;
                second_code = s.req.data;
                two_cycle = 1'b1;
            end
            FWC_OP_BLOCK_LOCK: begin
                first_code = `FWC_CMD_LOCK_SETUP;
                second_code = `FWC_CMD_BLOCK_LOCK;
                two_cycle = 1'b1;
            end
            FWC_OP_PERM_LOCK: begin
                first_code = `FWC_CMD_LOCK_SETUP;
                second_code = `FWC_CMD_PERM_LOCK;
                two_cycle = 1'b1;
            end
            FWC_OP_CLEAR_LOCKS: begin
                first_code = `FWC_CMD_LOCK_SETUP;
                second_code = `FWC_CMD_CLEAR_LOCKS;
                two_cycle = 1'b1;
            end
            FWC_OP_CLEAR_STATUS: begin
                first_code = `FWC_CMD_CLEAR_STATUS;
            end
            default: begin
                first_code = `FWC_CMD_READ_ARRAY;
            end
        endcase
    end

    // the bus cycle engine is already idle in the cycle done is high; busy tracks an outstanding cycle
    assign cyc_pending = s.busy && !cyc_done;
    assign cyc_issued = !s.busy && (s.st == ST_FIRST || s.st == ST_SECOND || s.st == ST_POLL
                                    || s.st == ST_CLEAR || s.st == ST_FINISH);

    always_comb begin
        cyc_start = cyc_issued && !cyc_pending;
        cyc_write = (s.st != ST_POLL);
        cyc_addr = s.req.addr;
        cyc_data = first_code;
        unique case (s.st)
            ST_SECOND: cyc_data = second_code;
            ST_CLEAR: cyc_data = `FWC_CMD_CLEAR_STATUS;
            ST_FINISH: cyc_data = `FWC_CMD_READ_ARRAY;
            default: cyc_data = first_code;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.rp_n = 1'b1;
        if (cyc_start) begin
            next_s.busy = 1'b1;
        end else if (cyc_done) begin
            next_s.busy = 1'b0;
        end
        unique case (s.st)
            ST_IDLE: begin
                // next command accepted once previous finished
                if (req_valid_in) begin
                    next_s.req = req_in;
                    next_s.st = ST_FIRST;
                    next_s.err_any = 1'b0;
                    next_s.err = '0;
                end
            end
            ST_FIRST: begin
                if (s.busy && cyc_done) begin
                    if (two_cycle) begin
                        next_s.st = ST_SECOND;
                    end else begin
                        next_s.st = ST_IDLE;
                        next_s.done = 1'b1;
                    end
                end
            end
            ST_SECOND: begin
                if (s.busy && cyc_done) begin
                    next_s.st = ST_POLL;
                end
            end
            ST_POLL: begin
                if (s.busy && cyc_done && cyc_rdata[`FWC_BIT_READY]) begin
                    if (s.req.full_check) begin
                        // bits sampled only from a ready status
                        // sticky bits may hold errors of earlier ops in a batch
                        next_s.err.supply_error = cyc_rdata[`FWC_BIT_SUPPLY_ERR];
                        next_s.err.protect_error = cyc_rdata[`FWC_BIT_PROTECT];
                        next_s.err.write_error = cyc_rdata[`FWC_BIT_WRITE_ERR];
                        next_s.err_any = cyc_rdata[`FWC_BIT_SUPPLY_ERR] | cyc_rdata[`FWC_BIT_PROTECT]
                                         | cyc_rdata[`FWC_BIT_WRITE_ERR];
                        if (cyc_rdata[`FWC_BIT_SUPPLY_ERR] | cyc_rdata[`FWC_BIT_PROTECT]
                            | cyc_rdata[`FWC_BIT_WRITE_ERR]) begin
                            next_s.st = ST_CLEAR;
                        end else begin
                            next_s.st = ST_FINISH;
                        end
                    end else begin
                        // batch mode leaves the check to a later op
                        next_s.st = ST_FINISH;
                    end
                end
            end
            ST_CLEAR: begin
                if (s.busy && cyc_done) begin
                    next_s.st = ST_FINISH;
                end
            end
            ST_FINISH: begin
                if (s.busy && cyc_done) begin
                    next_s.st = ST_IDLE;
                    next_s.done = 1'b1;
                end
            end
        endcase
        // ready is its own flop so the port needs no decode after the register
        next_s.ready = (next_s.st == ST_IDLE);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '{st: ST_IDLE, req: '0, busy: 1'b0, done: 1'b0, err: '0, err_any: 1'b0, rp_n: 1'b0,
                   ready: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // every port is a flop: state fields here, bus pins from the cycle engine
    assign req_ready_out = s.ready;
    assign done_out = s.done;
    assign err_out = s.err;
    assign err_any_out = s.err_any;
    assign addr_out = cyc_bus.addr;
    assign dq_out = cyc_bus.dq_out;
    assign dq_oe_out = cyc_bus.dq_oe;
    assign ce_n_out = cyc_bus.ce_n;
    assign we_n_out = cyc_bus.we_n;
    assign oe_n_out = cyc_bus.oe_n;
    assign reset_powerdown_pin_out = s.rp_n;
endmodule

// ---- fwc_flash_model.sv ----
// behavioural flash: command decoder, status bits, lock-bits, small array
// assumes strobes change on clk_in edges; busy time and faults come from the bench
`timescale 1ns/1ps
module fwc_flash_model #(
    parameter int BLK_LSB = 15
) (
    input wire logic clk_in,
    input wire logic rp_in,
    input wire logic ce_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic [18:0] addr_in,
    input wire logic [15:0] dq_in,
    input wire logic dq_oe_in,
    input wire logic [7:0] busy_cyc_in,
    input wire logic vpp_bad_in,
    input wire logic fail_in,
    output logic [15:0] dq_out
);
    logic [15:0] mem [256];
    logic [15:0] locks = '0;
    logic [15:0] last = '0;
    logic [15:0] cd;
    logic [18:0] ca;
    logic [7:0] sr, setup;
    logic perm = 1'b0;
    logic status_mode, wr_prev;
    int busy;
    initial foreach (mem[i]) mem[i] = 16'hffff;
    // unselected bus is not held, so show the inverse of the last value
    always_comb dq_out = (!ce_n_in && !oe_n_in) ? (status_mode ? {8'h00, sr} : mem[addr_in[7:0]]) : ~last;
    always @(posedge clk_in) begin
        if (!ce_n_in && !oe_n_in) last <= dq_out;
        if (!rp_in) begin
            sr <= 8'h80; status_mode <= 1'b0; setup <= 8'h00; busy <= 0; wr_prev <= 1'b0;
        end else begin
            wr_prev <= !ce_n_in && !we_n_in;
            if (!we_n_in && dq_oe_in) begin
                ca <= addr_in; cd <= dq_in;
            end
            if (busy == 1) sr[7] <= 1'b1;
            if (busy > 0) busy <= busy - 1;
            if (wr_prev && we_n_in) begin
                setup <= 8'h00;
                status_mode <= 1'b1;
                if (setup == 8'h40 || setup == 8'h60) begin
                    sr[7] <= 1'b0; busy <= busy_cyc_in;
                end
                if (setup == 8'h40) begin
                    if (locks[ca[BLK_LSB+:4]]) sr[1] <= 1'b1;
                    else if (vpp_bad_in) begin sr[3] <= 1'b1; sr[4] <= 1'b1; end
                    else if (fail_in) sr[4] <= 1'b1;
                    else mem[ca[7:0]] <= cd;
                end else if (setup == 8'h60) begin
                    if (cd[7:0] == 8'h01) locks[ca[BLK_LSB+:4]] <= 1'b1;
                    else if (cd[7:0] == 8'hf1) perm <= 1'b1;
                    else if (cd[7:0] == 8'hd0) locks <= '0;
                end else if (cd[7:0] == 8'h40 || cd[7:0] == 8'h60) setup <= cd[7:0];
                else if (cd[7:0] == 8'h50) sr[5:1] <= '0;
                else if (cd[7:0] == 8'hff) status_mode <= 1'b0;
            end
        end
    end
endmodule

// ---- fwc_pkg.sv ----
// types shared by the flash command controller files
// assumes fwc_cfg.svh is on the include path
`include "fwc_cfg.svh"
package fwc_pkg;
    typedef enum logic [2:0] {
        FWC_OP_PROGRAM,
        FWC_OP_BLOCK_LOCK,
        FWC_OP_PERM_LOCK,
        FWC_OP_CLEAR_LOCKS,
        FWC_OP_READ_ARRAY,
        FWC_OP_CLEAR_STATUS
    } fwc_op_e;
    typedef struct packed {
        fwc_op_e op;
        logic [`FWC_ADDR_W-1:0] addr;
        logic [`FWC_DATA_W-1:0] data;
        logic full_check;
    } fwc_req_s;
    typedef struct packed {
        logic supply_error;
        logic protect_error;
        logic write_error;
    } fwc_err_s;
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [`FWC_ADDR_W-1:0] addr;
        logic [`FWC_DATA_W-1:0] dq_out;
        logic dq_oe;
    } fwc_bus_s;
endpackage

// ---- tb_top.sv ----
// self-checking bench: controller driving a behavioural flash
// assumes the checker bind and fwc_flash_model are compiled with it
`timescale 1ns/1ps
`include "fwc_cfg.svh"
module tb_top;
    import fwc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    fwc_req_s req = '0;
    logic [7:0] busy_cyc = 8'h03;
    logic vpp_bad = 1'b0;
    logic fail = 1'b0;
    logic req_ready, done, err_any, dq_oe, ce_n, we_n, oe_n, rp;
    fwc_err_s err;
    logic [18:0] addr;
    logic [15:0] dq_o, dq_i;
    int bad_count = 0;
    int n_tests = 0;
    fwc_controller uut (.ref_clk_in(clk), .rst_n_in(rst_n), .req_valid_in(req_valid), .req_in(req),
        .dq_in(dq_i), .req_ready_out(req_ready), .done_out(done), .err_out(err), .err_any_out(err_any),
        .addr_out(addr), .dq_out(dq_o), .dq_oe_out(dq_oe), .ce_n_out(ce_n), .we_n_out(we_n),
        .oe_n_out(oe_n), .reset_powerdown_pin_out(rp));
    fwc_flash_model fm (.clk_in(clk), .rp_in(rp), .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n),
        .addr_in(addr), .dq_in(dq_o), .dq_oe_in(dq_oe), .busy_cyc_in(busy_cyc), .vpp_bad_in(vpp_bad),
        .fail_in(fail), .dq_out(dq_i));
    initial forever #20 clk = ~clk;
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task run_op(input fwc_op_e op, input logic [18:0] a, input logic [15:0] d, input logic fc);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{op: op, addr: a, data: d, full_check: fc};
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 50) begin @(negedge clk); n++; end
        @(posedge clk);
        req_valid <= 1'b0;
        while (done !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
        check(16'(n < 3000), 16'h0001);
    endtask
    task t_program;
        run_op(FWC_OP_PROGRAM, 19'h00012, 16'h1234, 1'b1);
        check(16'(err), 16'h0000);
        check(fm.mem[8'h12], 16'h1234);
        busy_cyc <= 8'h28;
        run_op(FWC_OP_PROGRAM, 19'h00013, 16'ha5c3, 1'b1);
        check(fm.mem[8'h13], 16'ha5c3);
        check(16'(fm.status_mode), 16'h0000);
        busy_cyc <= 8'h03;
    endtask
    task t_errors;
        vpp_bad <= 1'b1;
        run_op(FWC_OP_PROGRAM, 19'h00020, 16'h0f0f, 1'b1);
        check(16'(err), 16'h0005);
        check(16'(err_any), 16'h0001);
        check(16'(fm.sr[5:1]), 16'h0000);
        vpp_bad <= 1'b0;
        fail <= 1'b1;
        run_op(FWC_OP_PROGRAM, 19'h00021, 16'h0001, 1'b0);
        check(16'(err), 16'h0000);
        fail <= 1'b0;
        run_op(FWC_OP_PROGRAM, 19'h00022, 16'h0002, 1'b1);
        check(16'(err), 16'h0001);
        fail <= 1'b1;
        run_op(FWC_OP_PROGRAM, 19'h00023, 16'h0003, 1'b0);
        fail <= 1'b0;
        run_op(FWC_OP_CLEAR_STATUS, 19'h00000, 16'h0000, 1'b0);
        check(16'(fm.sr[4]), 16'h0000);
        run_op(FWC_OP_READ_ARRAY, 19'h00000, 16'h0000, 1'b0);
        check(16'(fm.status_mode), 16'h0000);
    endtask
    task t_locks;
        run_op(FWC_OP_BLOCK_LOCK, 19'h10005, 16'h0000, 1'b1);
        check(16'(fm.locks[2]), 16'h0001);
        check(16'(fm.status_mode), 16'h0000);
        run_op(FWC_OP_PROGRAM, 19'h10005, 16'h7777, 1'b1);
        check(16'(err), 16'h0002);
        check(fm.mem[8'h05], 16'hffff);
        run_op(FWC_OP_PERM_LOCK, 19'h00000, 16'h0000, 1'b1);
        check(16'(fm.perm), 16'h0001);
        run_op(FWC_OP_CLEAR_LOCKS, 19'h00000, 16'h0000, 1'b1);
        check(fm.locks, 16'h0000);
        run_op(FWC_OP_PROGRAM, 19'h10005, 16'h7777, 1'b1);
        check(fm.mem[8'h05], 16'h7777);
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check(16'(rp), 16'h0001);
        t_program();
        t_errors();
        t_locks();
        results();
    end
    // thirteen operations of under a thousand cycles each
    initial begin
        #800000;
        bad_count++;
        results();
    end
endmodule
